// >>> timer_unit_pkg.sv
// constants, register map and state layout of the triple timer unit
// assumes a 32-bit avalon-mm master and a single 125 mhz clock
package timer_unit_pkg;
	localparam int          TIMER_WIDTH     = 16;
	localparam int          TIMER_COUNT     = 3;
	localparam int          ADDR_WIDTH      = 6;
	localparam real         CLK_MHZ         = 125.0;
	// base tick every fourth clock, power save slows it eightfold
	localparam logic [4:0]  PRE_FAST_LAST   = 5'h03;
	localparam logic [4:0]  PRE_SLOW_LAST   = 5'h1f;
	localparam logic [4:0]  PRE_STEP        = 5'h01;
	// word index = {group, register}; groups 0..2 are timers, 3 is common
	localparam logic [1:0]  GROUP_COMMON    = 2'h3;
	localparam logic [1:0]  REG_COUNT       = 2'h0;
	localparam logic [1:0]  REG_PRIMARY     = 2'h1;
	localparam logic [1:0]  REG_ALTERNATE   = 2'h2;
	localparam logic [1:0]  REG_MODE        = 2'h3;
	localparam logic [1:0]  REG_INT_STATUS  = 2'h0;
	localparam logic [1:0]  REG_INT_MASK    = 2'h1;
	localparam logic [1:0]  REG_CONTROL     = 2'h2;
	// mode and control register fields, then reset and step constants
	localparam int          MODE_ENABLE     = 0;
	localparam int          MODE_INT_EN     = 1;
	localparam int          MODE_DUAL       = 2;
	localparam int          MODE_PRESCALE   = 3;
	localparam int          MODE_MAX_FLAG   = 4;
	localparam int          MODE_PHASE      = 5;
	localparam int          CONTROL_PSAVE   = 0;
	localparam logic [4:0]  MODE_RESET      = 5'h00;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [15:0] COUNT_STEP      = 16'h0001;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

	typedef struct packed {
		logic [2:0][15:0] count;
		logic [2:0][15:0] primary_max_count;
		logic [1:0][15:0] alternate_max_count;
		logic [2:0][4:0]  mode;
		logic [1:0]       alt_phase;
		logic [1:0]       pin;
		logic [2:0]       int_status;
		logic [2:0]       int_mask;
		logic             power_save;
		logic [4:0]       pre;
		logic             ack;
		logic [31:0]      rdata;
	} state_type;
endpackage

// >>> triple_timer_pwm_unit.sv
// triple 16-bit timer with two dual max-count pwm timers and a prescaler
// assumes an avalon-mm master on clk_i; pwm pins feed logic elsewhere
//
// How it works
// R1: the common tick that steps the timers comes every fourth clock cycle.
// R2: power save bit slows the common tick to one per 32 clocks.
// R3: every count register can be read by software at any time.
// R4: timers 0 and 1 have primary and alternate max plus a mode register.
// R5: dual mode drives pin high to primary max, low to alternate max.
// R6: prescale mode lets timer 2 terminal count clock timer 0 or 1.
// R7: each counter is sixteen bits wide.
// R8: timer 2 has only a primary max count and no pins.
// R9: full count with interrupt enable raises the timer's interrupt.
// R10: full count always sets the max count flag in the mode register.
// R11: counter restarts at zero after max; flag stays until cleared.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module triple_timer_pwm_unit (
	input  wire logic                                  clk_i,
	input  wire logic                                  reset_n_i,
	input  wire logic [timer_unit_pkg::ADDR_WIDTH-1:0] address_i,
	input  wire logic                                  read_i,
	input  wire logic                                  write_i,
	input  wire logic [31:0]                           writedata_i,
	input  wire logic [3:0]                            byteenable_i,
	output logic      [31:0]                           readdata_o,
	output logic                                       waitrequest_o,
	output logic                                       first_pwm_o,
	output logic                                       second_pwm_o,
	output logic                                       irq_o
);
	import timer_unit_pkg::*;

	state_type s_q;
	state_type s_d;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	function automatic logic [31:0] read_word(input state_type st,
		input logic [1:0] grp, input logic [1:0] rg);
		logic [31:0] r;
		r = READ_ZERO;
		if (grp == GROUP_COMMON) begin
			case (rg)
				REG_INT_STATUS: r[2:0] = st.int_status;
				REG_INT_MASK:   r[2:0] = st.int_mask;
				REG_CONTROL:    r[CONTROL_PSAVE] = st.power_save;
				default:        r = READ_ZERO;
			endcase
		end else begin
			case (rg)
				REG_COUNT:   r[15:0] = st.count[grp]; // [R3]
				REG_PRIMARY: r[15:0] = st.primary_max_count[grp];
				REG_ALTERNATE: begin
					if (grp != 2'h2) begin // [R8]
						r[15:0] = st.alternate_max_count[grp[0]];
					end
				end
				REG_MODE: begin
					r[4:0] = st.mode[grp];
					if (grp != 2'h2) begin
						r[MODE_PHASE] = st.alt_phase[grp[0]];
					end
				end
				default: r = READ_ZERO;
			endcase
		end
		return r;
	endfunction

	logic       tick;
	logic [2:0] tc;
	logic [1:0] grp;
	logic [1:0] rg;
	logic       accept_wr;
	logic [15:0] limit;

	always_comb begin
		s_d       = s_q;
		tc        = 3'h0;
		limit     = COUNT_RESET;
		grp       = address_i[5:4];
		rg        = address_i[3:2];
		accept_wr = write_i & s_q.ack;

		// common tick: quarter clock, slower in power save
		s_d.pre = s_q.pre + PRE_STEP;
		if (s_q.power_save) begin // [R2]
			tick = (s_q.pre == PRE_SLOW_LAST);
			if (s_q.pre == PRE_SLOW_LAST) begin
				s_d.pre = PRE_SLOW_LAST + PRE_STEP;
			end
		end else begin
			tick = (s_q.pre[1:0] == PRE_FAST_LAST[1:0]); // [R1]
		end

		// bus handshake: one wait cycle, read data latched in it
		s_d.ack = (read_i | write_i) & ~s_q.ack;
		if (read_i & ~s_q.ack) begin
			s_d.rdata = read_word(s_q, grp, rg);
		end

		// register writes, before hardware events so sets win
		if (accept_wr) begin
			if (grp == GROUP_COMMON) begin
				case (rg)
					REG_INT_STATUS: begin
						s_d.int_status = s_q.int_status & ~writedata_i[2:0];
					end
					REG_INT_MASK: begin
						if (byteenable_i[0]) begin
							s_d.int_mask = writedata_i[2:0];
						end
					end
					REG_CONTROL: begin
						if (byteenable_i[0]) begin
							s_d.power_save = writedata_i[CONTROL_PSAVE];
						end
					end
					default: begin
					end
				endcase
			end else begin
				case (rg)
					REG_COUNT: begin
						s_d.count[grp] = merge16(s_q.count[grp],
							writedata_i, byteenable_i);
					end
					REG_PRIMARY: begin // [R4]
						s_d.primary_max_count[grp] = merge16(
							s_q.primary_max_count[grp], writedata_i,
							byteenable_i);
					end
					REG_ALTERNATE: begin
						if (grp != 2'h2) begin
							s_d.alternate_max_count[grp[0]] = merge16(
								s_q.alternate_max_count[grp[0]],
								writedata_i, byteenable_i);
						end
					end
					REG_MODE: begin
						if (byteenable_i[0]) begin
							// max flag bit: writing zero clears it
							s_d.mode[grp] = writedata_i[4:0];
							s_d.mode[grp][MODE_MAX_FLAG] =
								s_q.mode[grp][MODE_MAX_FLAG] &
								writedata_i[MODE_MAX_FLAG];
							if (grp == 2'h2) begin
								s_d.mode[grp][MODE_DUAL] = 1'b0;
								s_d.mode[grp][MODE_PRESCALE] = 1'b0;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end

		// prescale timer: single max count, no pins
		if (s_q.mode[2][MODE_ENABLE] & tick) begin // [R8]
			if (s_q.count[2] == s_q.primary_max_count[2]) begin
				s_d.count[2] = COUNT_RESET; // [R11]
				tc[2] = 1'b1;
			end else begin
				s_d.count[2] = s_q.count[2] + COUNT_STEP; // [R7]
			end
		end

		// dual max-count timers
		for (int i = 0; i < 2; i++) begin
			limit = (s_q.mode[i][MODE_DUAL] & s_q.alt_phase[i]) ?
				s_q.alternate_max_count[i] : s_q.primary_max_count[i];
			if (s_q.mode[i][MODE_ENABLE] &
				(s_q.mode[i][MODE_PRESCALE] ? tc[2] : tick)) begin // [R6]
				if (s_q.count[i] == limit) begin
					s_d.count[i] = COUNT_RESET; // [R11]
					tc[i] = 1'b1;
					s_d.alt_phase[i] = ~s_q.alt_phase[i]; // [R5]
				end else begin
					s_d.count[i] = s_q.count[i] + COUNT_STEP; // [R7]
				end
			end
			if (!s_q.mode[i][MODE_DUAL]) begin
				s_d.pin[i] = s_d.alt_phase[i] ? 1'b0 : 1'b1;
			end else begin
				s_d.pin[i] = ~s_d.alt_phase[i]; // [R5]
			end
		end

		// full-count events: flag always, interrupt when enabled
		for (int i = 0; i < 3; i++) begin
			if (tc[i]) begin
				s_d.mode[i][MODE_MAX_FLAG] = 1'b1; // [R10] [R11]
				if (s_q.mode[i][MODE_INT_EN]) begin
					s_d.int_status[i] = 1'b1; // [R9]
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q.count               <= '0;
			s_q.primary_max_count   <= '0;
			s_q.alternate_max_count <= '0;
			s_q.mode                <= {MODE_RESET, MODE_RESET, MODE_RESET};
			s_q.alt_phase           <= 2'h0;
			s_q.pin                 <= 2'h3;
			s_q.int_status          <= 3'h0;
			s_q.int_mask            <= 3'h0;
			s_q.power_save          <= 1'b0;
			s_q.pre                 <= 5'h00;
			s_q.ack                 <= 1'b0;
			s_q.rdata               <= READ_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata_o    = s_q.rdata;
	assign waitrequest_o = (read_i | write_i) & ~s_q.ack;
	assign first_pwm_o   = s_q.pin[0];
	assign second_pwm_o  = s_q.pin[1];
	assign irq_o         = |(s_q.int_status & s_q.int_mask); // [R9]
endmodule

// >>> triple_timer_pwm_unit_properties.sv
// checker for bus answer timing, read data hold and pin pacing
// assumes it is bound onto the unit's top ports
`timescale 1ns/1ps
module triple_timer_pwm_unit_properties (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o,
	input wire logic        first_pwm_o,
	input wire logic        second_pwm_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_one_wait: assert property (
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("wait held over one cycle");
	a_wait_first: assert property (
		$rose(read_i || write_i) |-> waitrequest_o)
		else $error("no wait in first cycle");
	a_idle_ready: assert property (
		!(read_i || write_i) |-> !waitrequest_o)
		else $error("wait without request");
	a_rdata_hold: assert property (
		!(read_i && waitrequest_o) |=> $stable(readdata_o))
		else $error("read data moved without read");
	a_first_pace: assert property (
		$changed(first_pwm_o) |=> $stable(first_pwm_o)[*3])
		else $error("first pin faster than tick");
	a_second_pace: assert property (
		$changed(second_pwm_o) |=> $stable(second_pwm_o)[*3])
		else $error("second pin faster than tick");
	a_pins_reset: assert property (
		$rose(reset_n_i) |-> first_pwm_o && second_pwm_o)
		else $error("pins not high after reset");
	a_irq_reset: assert property (
		$rose(reset_n_i) |-> !irq_o)
		else $error("interrupt high after reset");
endmodule

// >>> triple_timer_pwm_unit_tb.sv
// testbench: register bus tasks and timer scenarios
// assumes the package, the unit and its checker are compiled first
`timescale 1ns/1ps
module triple_timer_pwm_unit_tb;
	import timer_unit_pkg::*;
	logic        clk_i       = 1'b0;
	logic        reset_n_i   = 1'b0;
	logic [5:0]  address_i   = 6'h00;
	logic        read_i      = 1'b0;
	logic        write_i     = 1'b0;
	logic [31:0] writedata_i = 32'h0000_0000;
	logic [3:0]  byteenable_i = 4'hf;
	logic [31:0] readdata_o, rd, rd2;
	logic        waitrequest_o, first_pwm_o, second_pwm_o, irq_o;
	int          fail_count  = 0;
	int          checks      = 0;
	int          n;
	triple_timer_pwm_unit i_triple_timer_pwm_unit (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(byteenable_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .first_pwm_o(first_pwm_o),
		.second_pwm_o(second_pwm_o), .irq_o(irq_o));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	task automatic wrap_up();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one transfer: request held until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		address_i   <= a;
		writedata_i <= d;
		read_i      <= !wr;
		write_i     <= wr;
		do @(negedge clk_i); while (waitrequest_o !== 1'b0);
		@(posedge clk_i);
		rd = readdata_o;
		read_i  <= 1'b0;
		write_i <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [5:0] a,
		input logic [31:0] exp, input logic [31:0] m);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd & m);
	endtask
	// two count reads whose sample edges lie k+3 clocks apart
	task automatic gap(input logic [5:0] a, input int k,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		rd2 = rd;
		repeat (k) @(posedge clk_i);
		bus(1'b0, a, 32'h0000_0000);
		chk("count step", exp, rd - rd2);
	endtask
	// clocks the first pin spends at lvl in one whole segment
	task automatic span(input logic lvl);
		n = 0;
		while (first_pwm_o === lvl && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		while (first_pwm_o !== lvl && n < 300) begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		while (first_pwm_o === lvl && n < 300) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rdc("mode0", 6'h0c, 32'h0000_0000, 32'hffff_ffff);
		rdc("count0", 6'h00, 32'h0000_0000, 32'hffff_ffff);
		chk("pin1 reset", 32'h0000_0001, {31'h0, second_pwm_o});
		bus(1'b1, 6'h04, 32'hffff_0003);
		bus(1'b1, 6'h08, 32'h0000_0001);
		rdc("prim0", 6'h04, 32'h0000_0003, 32'hffff_ffff);
		rdc("alt0", 6'h08, 32'h0000_0001, 32'hffff_ffff);
		byteenable_i <= 4'h2;
		bus(1'b1, 6'h04, 32'h0000_5a77);
		rdc("prim0 lane", 6'h04, 32'h0000_5a03, 32'hffff_ffff);
		byteenable_i <= 4'hf;
		bus(1'b1, 6'h04, 32'h0000_0003);
		rdc("prim0 back", 6'h04, 32'h0000_0003, 32'hffff_ffff);
		bus(1'b1, 6'h2c, 32'h0000_000c);
		rdc("mode2", 6'h2c, 32'h0000_0000, 32'hffff_ffff);
		bus(1'b1, 6'h24, 32'h0000_0001);
		bus(1'b1, 6'h28, 32'h0000_0055);
		rdc("alt2", 6'h28, 32'h0000_0000, 32'hffff_ffff);
		bus(1'b1, 6'h2c, 32'h0000_0001);
		bus(1'b1, 6'h14, 32'h0000_ffff);
		bus(1'b1, 6'h1c, 32'h0000_0009);
		gap(6'h10, 77, 32'h0000_000a);
		bus(1'b1, 6'h1c, 32'h0000_0001);
		gap(6'h10, 37, 32'h0000_000a);
		bus(1'b1, 6'h38, 32'h0000_0001);
		gap(6'h10, 125, 32'h0000_0004);
		bus(1'b1, 6'h38, 32'h0000_0000);
		bus(1'b1, 6'h0c, 32'h0000_0007);
		span(1'b1);
		chk("high span", 32'h0000_0010, n);
		span(1'b0);
		chk("low span", 32'h0000_0008, n);
		rdc("status", 6'h30, 32'h0000_0001, 32'hffff_ffff);
		rdc("flag0", 6'h0c, 32'h0000_0010, 32'h0000_0010);
		rdc("flag2", 6'h2c, 32'h0000_0010, 32'h0000_0010);
		chk("irq masked", 32'h0000_0000, {31'h0, irq_o});
		bus(1'b1, 6'h34, 32'h0000_0001);
		@(negedge clk_i);
		chk("irq", 32'h0000_0001, {31'h0, irq_o});
		bus(1'b1, 6'h0c, 32'h0000_0000);
		bus(1'b1, 6'h30, 32'h0000_0007);
		bus(1'b1, 6'h0c, 32'h0000_0000);
		@(negedge clk_i);
		chk("irq clear", 32'h0000_0000, {31'h0, irq_o});
		rdc("flag clr", 6'h0c, 32'h0000_0000, 32'h0000_0010);
		rdc("unmapped", 6'h3c, 32'h0000_0000, 32'hffff_ffff);
		wrap_up();
	end
endmodule
bind triple_timer_pwm_unit triple_timer_pwm_unit_properties i_props (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .read_i(read_i),
	.write_i(write_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .first_pwm_o(first_pwm_o),
	.second_pwm_o(second_pwm_o), .irq_o(irq_o));
